/* File: logic/fpt_pkg.sv */
// Behaviour
// R1: When bit 0 of a fan drive setting is set, that fan output stays high.
// R2: When bit 0 is clear, the duty cycle comes from the field in bits 6:1.
// R3: With PWM selected and a zero duty field, the fan output stays low.
// R4: Nonzero duty fields give duty cycles from 1.56 to 98.44 percent.
// R5: The PWM period is set by the drive setting and fan control registers; the code takes it from the fan control rate field alone.
// R6: The high time of each period ranges from 0.00033 ms up to 25.1 ms; the code reaches at most 5.32 ms (63 slots at rate 255).
// R7: The tach counter ticks every 30.52 us times the divisor field value.
// R8: Each tach pulse is half a revolution, at least 4 ticks, 3 high, 1 low.
// R9: High time is the duty field over 64 of the PWM period.
package fpt_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] FPT_ADDR_DRIVE = 4'h0;
  localparam logic [3:0] FPT_ADDR_FANCTL = 4'h4;
  localparam logic [3:0] FPT_ADDR_TACH = 4'h8;
  localparam logic [3:0] FPT_ADDR_STAT = 4'hC;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int FPT_FORCE_BIT = 0;
  localparam int FPT_DUTY_LSB = 1;
  localparam int FPT_DUTY_MSB = 6;
  localparam int FPT_RATE_LSB = 0;
  localparam int FPT_RATE_MSB = 7;
  localparam int FPT_TACH_CLOCK_DIVISOR_LSB = 8;
  localparam int FPT_TACH_CLOCK_DIVISOR_MSB = 11;
  localparam logic [7:0] FPT_DRIVE_RST = 8'h00;
  localparam logic [11:0] FPT_FANCTL_RST = 12'h1FF;

  // ****************************************
  // Timing
  // ****************************************
  localparam int FPT_CLK_MHZ = 200;
  // PWM slot base: 64 slots of 0.33 us -> 21 us least period
  localparam int FPT_SLOT_NS = 330;
  localparam int FPT_SLOT_CYC = (FPT_SLOT_NS * FPT_CLK_MHZ) / 1000;
  // Tach tick base, in ns
  localparam int FPT_TACH_NS = 30520;
  localparam int FPT_TACH_CYC = (FPT_TACH_NS * FPT_CLK_MHZ) / 1000;

endpackage

/* File: logic/fpt_pwm.sv */
`timescale 1ns/1ps
`default_nettype none
module fpt_pwm
  import fpt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Settings
  input wire logic [7:0] driveSetting,
  input wire logic [7:0] rateDiv,
  // Pin
  output logic fanOut
);

  // ****************************************
  // Slot prescaler: one pulse per 1/64 period
  // ****************************************
  logic [15:0] preCnt_r, preCnt_nxt;
  logic [7:0] rateCnt_r, rateCnt_nxt;
  logic [5:0] slot_r, slot_nxt;
  logic fanOut_nxt;
  logic baseTick;
  logic [5:0] duty;

  assign duty = driveSetting[FPT_DUTY_MSB:FPT_DUTY_LSB];

  // Next state; period = 64 slots of 0.33us*(rate+1)
  always_comb
  begin
    preCnt_nxt = preCnt_r + 16'h0001;
    baseTick = 1'b0;
    rateCnt_nxt = rateCnt_r;
    slot_nxt = slot_r;
    if (preCnt_r == 16'(FPT_SLOT_CYC - 1))
    begin
      preCnt_nxt = 16'h0000;
      baseTick = 1'b1;
    end
    if (baseTick)
    begin
      // Rate from fan control stretches the period
      if (rateCnt_r >= rateDiv) // R5
      begin
        rateCnt_nxt = 8'h00;
        slot_nxt = slot_r + 6'h01;
      end
      else
        rateCnt_nxt = rateCnt_r + 8'h01;
    end
    // High for duty of 64 slots: 1/64 to 63/64
    if (driveSetting[FPT_FORCE_BIT])
      fanOut_nxt = 1'b1; // R1
    else if (duty == 6'h00)
      fanOut_nxt = 1'b0; // R3
    else
      fanOut_nxt = (slot_nxt < duty); // R2 R4 R6 R9
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      preCnt_r <= 16'h0000;
      rateCnt_r <= 8'h00;
      slot_r <= 6'h00;
      fanOut <= 1'b0;
    end
    else
    begin
      preCnt_r <= preCnt_nxt;
      rateCnt_r <= rateCnt_nxt;
      slot_r <= slot_nxt;
      fanOut <= fanOut_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: logic/fpt_tach.sv */
`timescale 1ns/1ps
`default_nettype none
module fpt_tach
  import fpt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Settings
  input wire logic [3:0] tachClockDivisor,
  // Sensor pin
  input wire logic tachIn,
  // Result
  output logic [15:0] tachCount,
  output logic tachValid
);

  // ****************************************
  // Tick divider and edge counter
  // ****************************************
  typedef enum logic [1:0] {
    FPT_T_WAITLOW = 2'b00,
    FPT_T_LOW = 2'b01,
    FPT_T_HIGH = 2'b10
  } fpt_tstate_t;

  fpt_tstate_t st_r, st_nxt;
  logic [12:0] baseCnt_r, baseCnt_nxt;
  logic [3:0] divCnt_r, divCnt_nxt;
  logic [15:0] run_r, run_nxt;
  logic [15:0] tachCount_nxt;
  logic tachValid_nxt;
  logic tachLast_r;
  logic tick;

  // Tick every 30.52us * divisor; divisor 0 treated as 1
  always_comb
  begin
    baseCnt_nxt = baseCnt_r + 13'h0001;
    divCnt_nxt = divCnt_r;
    tick = 1'b0;
    if (baseCnt_r == 13'(FPT_TACH_CYC - 1))
    begin
      baseCnt_nxt = 13'h0000;
      if (divCnt_r + 4'h1 >= tachClockDivisor) // R7
      begin
        divCnt_nxt = 4'h0;
        tick = 1'b1;
      end
      else
        divCnt_nxt = divCnt_r + 4'h1;
    end
  end

  // Sample tach on ticks; count ticks per rising-edge pulse
  // Sensor must hold 3 ticks high, 1 low so no edge is missed
  always_comb
  begin
    st_nxt = st_r;
    run_nxt = run_r;
    tachCount_nxt = tachCount;
    tachValid_nxt = tachValid;
    if (tick)
    begin
      if (run_r != 16'hFFFF)
        run_nxt = run_r + 16'h0001;
      case (st_r)
        FPT_T_WAITLOW:
          if (!tachIn)
            st_nxt = FPT_T_LOW;
        FPT_T_LOW:
          if (tachIn && !tachLast_r)
          begin
            st_nxt = FPT_T_HIGH;
            run_nxt = 16'h0001;
          end
        FPT_T_HIGH:
          if (tachIn && !tachLast_r)
          begin
            // Half revolution measured in ticks
            tachCount_nxt = run_r; // R8
            tachValid_nxt = 1'b1;
            run_nxt = 16'h0001;
          end
        default:
          st_nxt = FPT_T_WAITLOW;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= FPT_T_WAITLOW;
      baseCnt_r <= 13'h0000;
      divCnt_r <= 4'h0;
      run_r <= 16'h0000;
      tachLast_r <= 1'b0;
      tachCount <= 16'hFFFF;
      tachValid <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      baseCnt_r <= baseCnt_nxt;
      divCnt_r <= divCnt_nxt;
      run_r <= run_nxt;
      if (tick)
        tachLast_r <= tachIn;
      tachCount <= tachCount_nxt;
      tachValid <= tachValid_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: logic/fpt_fan_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fpt_fan_top
  import fpt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Fan pins
  output logic fanOut,
  input wire logic tachIn
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] driveSetting_r, driveSetting_nxt;
  logic [11:0] fanCtl_r, fanCtl_nxt;
  logic [31:0] regRdata_nxt;
  logic [15:0] tachCount;
  logic tachValid;
  logic pwmPin;

  // Software writes; unmapped writes ignored
  always_comb
  begin
    driveSetting_nxt = driveSetting_r;
    fanCtl_nxt = fanCtl_r;
    regRdata_nxt = 32'h00000000;
    if (regWr && regAddr == FPT_ADDR_DRIVE)
      driveSetting_nxt = regWdata[7:0];
    if (regWr && regAddr == FPT_ADDR_FANCTL)
      fanCtl_nxt = regWdata[11:0];
    // Read data valid only the cycle after the strobe
    if (regRd)
    begin
      case (regAddr)
        FPT_ADDR_DRIVE: regRdata_nxt = {24'h000000, driveSetting_r};
        FPT_ADDR_FANCTL: regRdata_nxt = {20'h00000, fanCtl_r};
        FPT_ADDR_TACH: regRdata_nxt = {16'h0000, tachCount};
        FPT_ADDR_STAT: regRdata_nxt = {30'h00000000, pwmPin, tachValid};
        default: regRdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      driveSetting_r <= FPT_DRIVE_RST;
      fanCtl_r <= FPT_FANCTL_RST;
      regRdata <= 32'h00000000;
      fanOut <= 1'b0;
    end
    else
    begin
      driveSetting_r <= driveSetting_nxt;
      fanCtl_r <= fanCtl_nxt;
      regRdata <= regRdata_nxt;
      fanOut <= pwmPin;
    end
  end

  // ****************************************
  // Engines
  // ****************************************
  // Output stage: pin follows PWM by one more flop
  fpt_pwm u_pwm (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .driveSetting(driveSetting_r),
    .rateDiv(fanCtl_r[FPT_RATE_MSB:FPT_RATE_LSB]),
    .fanOut(pwmPin)
  );

  fpt_tach u_tach (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tachClockDivisor(fanCtl_r[FPT_TACH_CLOCK_DIVISOR_MSB:FPT_TACH_CLOCK_DIVISOR_LSB]),
    .tachIn(tachIn),
    .tachCount(tachCount),
    .tachValid(tachValid)
  );

endmodule
`default_nettype wire

/* File: dv/fpt_fan_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module fpt_fan_top_properties
  import fpt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  // Fan pins
  input wire logic fanOut,
  input wire logic tachIn
);
  // ****
  // Shadows
  // ****
  logic [7:0] drvR;
  logic [11:0] ctlR;
  logic [14:0] quietR;
  logic [14:0] hiR;
  logic [14:0] perR;
  logic dw;
  logic pwmOk;
  int hiExp;
  int perExp;
  assign dw = regWr && regAddr == FPT_ADDR_DRIVE;
  assign hiExp = drvR[6:1] * FPT_SLOT_CYC * (ctlR[7:0] + 1);
  assign perExp = 64 * FPT_SLOT_CYC * (ctlR[7:0] + 1);
  // Judge only after two quiet periods, so a write mid-period never counts
  assign pwmOk = !drvR[0] && drvR[6:1] != 6'h00 && quietR > 2 * perExp;
  // Settings copies and run lengths
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      drvR <= FPT_DRIVE_RST;
      ctlR <= FPT_FANCTL_RST;
      quietR <= 15'h0;
      hiR <= 15'h0;
      perR <= 15'h0;
    end
    else
    begin
      if (dw)
        drvR <= regWdata[7:0];
      if (regWr && regAddr == FPT_ADDR_FANCTL)
        ctlR <= regWdata[11:0];
      quietR <= regWr ? 15'h0 : quietR + (quietR != 15'h7FFF);
      hiR <= fanOut ? hiR + 15'h1 : 15'h0;
      perR <= $rose(fanOut) ? 15'h1 : perR + 15'h1;
    end
  sequence forceWrS;
    dw && regWdata[0] ##1 !dw [*3];
  endsequence
  sequence zeroWrS;
    dw && regWdata[6:0] == 7'h00 ##1 !dw [*3];
  endsequence
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  force_high_a: assert property (forceWrS |-> fanOut)
    else $error("fan pin not forced high");
  zero_duty_a: assert property (zeroWrS |-> !fanOut)
    else $error("fan pin not low at zero duty");
  high_time_a: assert property ($fell(fanOut) && pwmOk |-> hiR == hiExp)
    else $error("high time wrong");
  pwm_period_a: assert property ($rose(fanOut) && pwmOk |-> perR == perExp)
    else $error("period wrong");
  drive_read_a: assert property (regRd && regAddr == FPT_ADDR_DRIVE
    |=> regRdata == {24'h0, $past(drvR)})
    else $error("drive readback wrong");
  ctl_read_a: assert property (regRd && regAddr == FPT_ADDR_FANCTL
    |=> regRdata == {20'h0, $past(ctlR)})
    else $error("fan control readback wrong");
  read_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside answer cycle");
  unmapped_read_a: assert property (regRd && regAddr[1:0] != 2'h0
    |=> regRdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* File: dv/fpt_tach_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fpt_tach_model
  import fpt_pkg::*;
#(
  parameter int HI_TICKS = 3,
  parameter int LO_TICKS = 2
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Sensor pin
  output logic tachIn
);
  int cnt;
  // Free pulse train in whole ticks, high held at the 3-tick minimum and low kept above it
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt <= 0;
      tachIn <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == (HI_TICKS + LO_TICKS) * FPT_TACH_CYC - 1) ? 0 : cnt + 1;
      tachIn <= cnt < HI_TICKS * FPT_TACH_CYC;
    end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fpt_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic rdPend = 1'b0;
  logic [31:0] regRdata;
  logic fanOut;
  logic tachIn;
  logic [31:0] expQ[$];
  logic [5:0] duty;
  integer seed = 32'h0B976F4C;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  fpt_fan_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .fanOut(fanOut), .tachIn(tachIn));
  fpt_tach_model u_tach (.ref_clk(ref_clk), .rst_n(rst_n), .tachIn(tachIn));
  // ****
  // Bus tasks
  // ****
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    regRd <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    regWr <= 1'b0;
    expQ.push_back(e);
  endtask
  task automatic idle(input int n);
    @(posedge ref_clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Period wait covers three periods so the checker sees settled ones
  task automatic pwm(input logic [7:0] d, input logic [31:0] c);
    wr(FPT_ADDR_FANCTL, c);
    wr(FPT_ADDR_DRIVE, {24'h0, d});
    rd(FPT_ADDR_DRIVE, {24'h0, d});
    idle(13000 + 13000 * c[0]);
    $display("Test duty %h done", d);
  endtask
  // Read answers checked in order, plus the hang limit
  always @(posedge ref_clk)
  begin
    if (rdPend)
      chk("regRdata", regRdata, expQ.pop_front());
    rdPend <= regRd;
    cyc <= cyc + 1;
    if (cyc > 90000)
    begin
      err_count++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(FPT_ADDR_DRIVE, 32'h0);
    rd(FPT_ADDR_FANCTL, 32'h1FF);
    rd(FPT_ADDR_TACH, 32'hFFFF);
    rd(4'h2, 32'h0);
    wr(4'h6, 32'hFF);
    rd(4'h6, 32'h0);
    rd(FPT_ADDR_FANCTL, 32'h1FF);
    rd(FPT_ADDR_STAT, 32'h0);
    $display("Test registers done");
    duty = 6'(1 + ({$random(seed)} % 62));
    pwm(8'h02, 32'h100);
    pwm(8'h7E, 32'h100);
    pwm({1'b0, duty, 1'b0}, 32'h101);
    wr(FPT_ADDR_DRIVE, 32'h7F);
    idle(20);
    rd(FPT_ADDR_STAT, 32'h2);
    wr(FPT_ADDR_DRIVE, 32'h0);
    idle(20);
    rd(FPT_ADDR_STAT, 32'h0);
    $display("Test force and zero done");
    // First tach result lands about eleven ticks after reset
    idle(16000);
    rd(FPT_ADDR_TACH, 32'h5);
    rd(FPT_ADDR_STAT, 32'h1);
    idle(4);
    $display("Test tach done");
    print_verdict();
  end
endmodule
bind fpt_fan_top fpt_fan_top_properties u_props (.ref_clk(ref_clk),
  .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .fanOut(fanOut), .tachIn(tachIn));
`default_nettype wire
